// File: oasf_map.svh
// register offsets, field positions, reset values and step constants
`ifndef OASF_MAP_SVH
`define OASF_MAP_SVH
`define OASF_OFF_FLAGS 12'h000
`define OASF_OFF_CTRL 12'h004
`define OASF_OFF_LAST_EA 12'h008
`define OASF_FLAGS_RST 16'h0000
`define OASF_FLAGS_WMASK 16'hfe0f
`define OASF_CTRL_RST 1'b0
`define OASF_CTRL_HOLD_POS 0
`define OASF_LGT_POS 15
`define OASF_AGT_POS 14
`define OASF_EQ_POS 13
`define OASF_CARRY_POS 12
`define OASF_OVF_POS 11
`define OASF_PAR_POS 10
`define OASF_XOP_POS 9
`define OASF_RSVD_HI 8
`define OASF_RSVD_LO 4
`define OASF_MASK_LSB 0
`define OASF_MASK_W 4
`define OASF_BYTE_POS 12
`define OASF_TS_LSB 4
`define OASF_S_LSB 0
`define OASF_TD_LSB 10
`define OASF_D_LSB 6
`define OASF_AINC_BYTE 16'h0001
`define OASF_AINC_WORD 16'h0002
`define OASF_OVF_VALUE 16'h8000
`define OASF_PAR_MIN_CNT 5'h01
`define OASF_PAR_MAX_CNT 5'h08
`endif

// File: oasf_pkg.sv
// types shared by the address and status flag block
package oasf_pkg;
    typedef enum logic [1:0] {
        OASF_MD_REG = 2'b00,
        OASF_MD_IND = 2'b01,
        OASF_MD_SYM = 2'b10,
        OASF_MD_AINC = 2'b11
    } oasf_mode_t;
    typedef enum logic [1:0] {
        OASF_EA_REG = 2'b00,
        OASF_EA_MEM = 2'b01,
        OASF_EA_IMM = 2'b10
    } oasf_ea_kind_t;
    typedef enum logic [4:0] {
        OASF_OP_NONE, OASF_OP_ADD, OASF_OP_SUB, OASF_OP_CMP, OASF_OP_CMPI,
        OASF_OP_MOVE, OASF_OP_LOGIC, OASF_OP_COC, OASF_OP_CZC, OASF_OP_TB,
        OASF_OP_ABS, OASF_OP_NEG, OASF_OP_INC, OASF_OP_DEC, OASF_OP_SLA,
        OASF_OP_SHIFT, OASF_OP_DIV, OASF_OP_SERIAL, OASF_OP_XOP,
        OASF_OP_MASK_LOAD_OP, OASF_OP_CONTEXT_RETURN
    } oasf_op_t;
    typedef enum logic [1:0] {
        OASF_APB_IDLE = 2'b00,
        OASF_APB_RESP = 2'b01
    } oasf_apb_st_t;
    typedef struct packed {
        logic [15:0] instr;
        logic dstSide;
        logic immed;
        logic [15:0] regVal;
        logic [15:0] extWord;
        logic [15:0] pc;
        logic [15:0] serialBase;
    } oasf_ea_req_t;
    typedef struct packed {
        oasf_ea_kind_t kind;
        logic [3:0] regSel;
        logic byteOp;
        logic [15:0] addr;
        logic [15:0] ptrNext;
        logic ptrWr;
        logic extUsed;
        logic [15:0] pcTarget;
        logic [11:0] bitAddr;
    } oasf_ea_rsp_t;
    typedef struct packed {
        oasf_op_t op;
        logic byteOp;
        logic [15:0] src;
        logic [15:0] dst;
        logic [15:0] result;
        logic carryOut;
        logic shiftOut;
        logic serialInBit;
        logic [4:0] bitCount;
    } oasf_flag_req_t;
endpackage

// File: oasf_ea_gen.sv
// operand effective address generation for one operand field
`timescale 1ns/1ps
`include "oasf_map.svh"
module oasf_ea_gen import oasf_pkg::*; (
    input wire oasf_ea_req_t req,
    output oasf_ea_rsp_t rsp
);
    logic [1:0] modeBits;
    logic [15:0] stepV;
    always_comb begin
        modeBits = req.dstSide ? req.instr[`OASF_TD_LSB +: 2]
                               : req.instr[`OASF_TS_LSB +: 2];
        rsp = '0;
        rsp.regSel = req.dstSide ? req.instr[`OASF_D_LSB +: 4]
                                 : req.instr[`OASF_S_LSB +: 4];
        rsp.byteOp = req.instr[`OASF_BYTE_POS];
        stepV = rsp.byteOp ? `OASF_AINC_BYTE : `OASF_AINC_WORD;
        rsp.kind = OASF_EA_MEM;
        if (req.immed) begin
            rsp.kind = OASF_EA_IMM;
            rsp.addr = req.extWord;
            rsp.extUsed = 1'b1;
        end else begin
            case (oasf_mode_t'(modeBits))
                OASF_MD_REG: begin
                    rsp.kind = OASF_EA_REG;
                end
                OASF_MD_IND: begin
                    rsp.addr = req.regVal;
                end
                OASF_MD_AINC: begin
                    rsp.addr = req.regVal;
                    rsp.ptrNext = req.regVal + stepV;
                    rsp.ptrWr = 1'b1;
                end
                default: begin
                    rsp.extUsed = 1'b1;
                    if (rsp.regSel == 4'h0) begin
                        rsp.addr = req.extWord;
                    end else begin
                        rsp.addr = req.extWord + req.regVal;
                    end
                end
            endcase
        end
    end
endmodule // oasf_ea_gen

// File: oasf_branch_gen.sv
// relative jump target and serial bit address from the displacement byte
`timescale 1ns/1ps
module oasf_branch_gen (
    input wire logic [15:0] instr,
    input wire logic [15:0] pc,
    input wire logic [15:0] serialBase,
    output logic [15:0] pcTarget,
    output logic [11:0] bitAddr
);
    logic [7:0] disp;
    always_comb begin
        disp = instr[7:0];
        pcTarget = pc + {{7{disp[7]}}, disp, 1'b0};
        bitAddr = serialBase[12:1] + {{4{disp[7]}}, disp};
    end
endmodule // oasf_branch_gen

// File: oasf_core.sv
// address generation, status flags and apb register slave
//
// Summary of operation
// - register mode uses workspace register as operand
// - auto-increment reads via pointer, then advances it
// - pointer step is one for byte, two word
// - direct mode takes extension word as address
// - indexed mode adds extension base and index register
// - mode field 00/01/11/10; register zero never indexes
// - immediate operand is the following word itself
// - jump adds doubled signed displacement to pc
// - bit address is serial base plus displacement
// - flags high, mask low, middle bits zero
// - compare sets logical-greater from signs and difference
// - compare immediate sets arithmetic-greater likewise
// - arithmetic, move, logic, shift and serial ops compare result against zero; abs compares its source
// - equal from compares, mask tests, input bit, zero
// - carry from adder or last shifted bit
// - add overflow on like signs, changed result sign
// - subtract overflow on unlike signs, changed sign
// - overflow for shift, step sign flip, 8000 hex
// - divide overflow when quotient cannot fit
// - byte parity from result or source byte
// - serial parity only for counts one to eight
// - trap instruction sets extended-operation flag
// - mask from immediate word or saved flags
// - byte-select bit chooses byte or word operands
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "oasf_map.svh"
module oasf_core import oasf_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic eaReqValid,
    input wire oasf_ea_req_t eaReq,
    output logic eaRspValid,
    output oasf_ea_rsp_t eaRsp,
    input wire logic flagReqValid,
    input wire oasf_flag_req_t flagReq,
    output logic flagsUpdated,
    output logic [15:0] cpuFlags
);
    oasf_apb_st_t apbState_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic [15:0] flags_ff;
    logic [15:0] nxt_flags;
    logic ctrlHold_ff;
    logic [15:0] lastEa_ff;
    logic eaRspValid_ff;
    oasf_ea_rsp_t eaRsp_ff;
    oasf_ea_rsp_t eaComb;
    logic flagsUpdated_ff;
    logic [15:0] pcTargetC;
    logic [11:0] bitAddrC;
    logic apbCommit;
    logic [15:0] sV;
    logic [15:0] dV;
    logic [15:0] rV;
    logic [15:0] diffV;
    logic topSame;
    logic cmpLgt;
    logic cmpAgt;
    logic [16:0] slaShift;
    logic [15:0] topMask;
    logic slaChg;
    logic serCntOk;

    // byte operands live in the high byte; low byte is ignored
    function automatic logic [15:0] laneOf(logic [15:0] v, logic b);
        return b ? {v[15:8], 8'h00} : v;
    endfunction

    // logical-greater, arithmetic-greater, equal against zero
    function automatic logic [2:0] zeroCmp(logic [15:0] v);
        return {|v, (|v) & ~v[15], ~|v};
    endfunction

    function automatic logic isMapped(logic [11:0] a);
        if (a == `OASF_OFF_FLAGS) begin
            return 1'b1;
        end else if (a == `OASF_OFF_CTRL) begin
            return 1'b1;
        end else if (a == `OASF_OFF_LAST_EA) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction

    oasf_ea_gen u_ea_gen (
        .req(eaReq),
        .rsp(eaComb)
    );

    oasf_branch_gen u_branch_gen (
        .instr(eaReq.instr),
        .pc(eaReq.pc),
        .serialBase(eaReq.serialBase),
        .pcTarget(pcTargetC),
        .bitAddr(bitAddrC)
    );

    // address results are registered one cycle after the request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eaRsp_ff <= '0;
            eaRspValid_ff <= 1'b0;
        end else begin
            eaRspValid_ff <= eaReqValid;
            if (eaReqValid) begin
                eaRsp_ff <= eaComb;
                eaRsp_ff.pcTarget <= pcTargetC;
                eaRsp_ff.bitAddr <= bitAddrC;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lastEa_ff <= 16'h0000;
        end else if (eaReqValid) begin
            lastEa_ff <= eaComb.addr;
        end
    end

    always_comb begin
        sV = laneOf(flagReq.src, flagReq.byteOp);
        dV = laneOf(flagReq.dst, flagReq.byteOp);
        rV = laneOf(flagReq.result, flagReq.byteOp);
        diffV = dV - sV;
        topSame = (sV[15] == dV[15]);
        cmpLgt = (sV[15] & ~dV[15]) | (topSame & diffV[15]);
        cmpAgt = (~sV[15] & dV[15]) | (topSame & diffV[15]);
        slaShift = 17'h0ffff >> ({1'b0, flagReq.bitCount} + 6'h01);
        topMask = ~slaShift[15:0];
        slaChg = ((sV & topMask) != 16'h0000) && ((sV & topMask) != topMask);
        serCntOk = (flagReq.bitCount >= `OASF_PAR_MIN_CNT)
                && (flagReq.bitCount <= `OASF_PAR_MAX_CNT);
        nxt_flags = flags_ff;
        case (flagReq.op)
            OASF_OP_ADD, OASF_OP_SUB: begin
                nxt_flags[`OASF_LGT_POS -: 3] = zeroCmp(rV);
                nxt_flags[`OASF_CARRY_POS] = flagReq.carryOut;
                if (flagReq.op == OASF_OP_ADD) begin
                    nxt_flags[`OASF_OVF_POS] = topSame
                        & (rV[15] != dV[15]);
                end else begin
                    nxt_flags[`OASF_OVF_POS] = ~topSame
                        & (rV[15] != dV[15]);
                end
                if (flagReq.byteOp) begin
                    nxt_flags[`OASF_PAR_POS] = ^rV;
                end
            end
            OASF_OP_CMP, OASF_OP_CMPI: begin
                nxt_flags[`OASF_LGT_POS] = cmpLgt;
                nxt_flags[`OASF_AGT_POS] = cmpAgt;
                nxt_flags[`OASF_EQ_POS] = (sV == dV);
                if (flagReq.byteOp) begin
                    nxt_flags[`OASF_PAR_POS] = ^sV;
                end
            end
            OASF_OP_MOVE, OASF_OP_LOGIC: begin
                nxt_flags[`OASF_LGT_POS -: 3] = zeroCmp(rV);
                if (flagReq.byteOp) begin
                    nxt_flags[`OASF_PAR_POS] = (flagReq.op == OASF_OP_MOVE)
                        ? ^sV : ^rV;
                end
            end
            OASF_OP_COC: begin
                nxt_flags[`OASF_EQ_POS] =
                    ((sV & ~dV) == 16'h0000);
            end
            OASF_OP_CZC: begin
                nxt_flags[`OASF_EQ_POS] = ((sV & dV) == 16'h0000);
            end
            OASF_OP_TB: begin
                nxt_flags[`OASF_EQ_POS] = flagReq.serialInBit;
            end
            OASF_OP_ABS, OASF_OP_NEG: begin
                nxt_flags[`OASF_LGT_POS -: 3] = zeroCmp(
                    (flagReq.op == OASF_OP_ABS) ? sV : rV);
                nxt_flags[`OASF_CARRY_POS] = flagReq.carryOut;
                nxt_flags[`OASF_OVF_POS] =
                    (flagReq.src == `OASF_OVF_VALUE);
            end
            OASF_OP_INC, OASF_OP_DEC: begin
                nxt_flags[`OASF_LGT_POS -: 3] = zeroCmp(rV);
                nxt_flags[`OASF_CARRY_POS] = flagReq.carryOut;
                nxt_flags[`OASF_OVF_POS] = (flagReq.op == OASF_OP_INC)
                    ? (~sV[15] & rV[15]) : (sV[15] & ~rV[15]);
            end
            OASF_OP_SLA, OASF_OP_SHIFT: begin
                nxt_flags[`OASF_LGT_POS -: 3] = zeroCmp(rV);
                nxt_flags[`OASF_CARRY_POS] = flagReq.shiftOut;
                if (flagReq.op == OASF_OP_SLA) begin
                    nxt_flags[`OASF_OVF_POS] = slaChg;
                end
            end
            OASF_OP_DIV: begin
                nxt_flags[`OASF_OVF_POS] = (~sV[15] & dV[15])
                    | (topSame & ~diffV[15]);
            end
            OASF_OP_SERIAL: begin
                nxt_flags[`OASF_LGT_POS -: 3] = zeroCmp(rV);
                nxt_flags[`OASF_PAR_POS] = serCntOk & (^sV);
            end
            OASF_OP_XOP: begin
                nxt_flags[`OASF_XOP_POS] = 1'b1;
            end
            OASF_OP_MASK_LOAD_OP: begin
                nxt_flags[`OASF_MASK_LSB +: `OASF_MASK_W] =
                    flagReq.src[`OASF_MASK_LSB +: `OASF_MASK_W];
            end
            OASF_OP_CONTEXT_RETURN: begin
                nxt_flags = flagReq.src & `OASF_FLAGS_WMASK;
            end
            default: begin
                nxt_flags = flags_ff;
            end
        endcase
    end

    assign apbCommit = psel && penable && pready_ff;

    // a flag update from the sequencer wins over a software write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_ff <= `OASF_FLAGS_RST;
            flagsUpdated_ff <= 1'b0;
        end else begin
            flagsUpdated_ff <= flagReqValid && !ctrlHold_ff;
            if (flagReqValid && !ctrlHold_ff) begin
                flags_ff <= nxt_flags & `OASF_FLAGS_WMASK;
            end else if (apbCommit && pwrite
                         && paddr == `OASF_OFF_FLAGS) begin
                flags_ff <= pwdata[15:0] & `OASF_FLAGS_WMASK;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrlHold_ff <= `OASF_CTRL_RST;
        end else if (apbCommit && pwrite && paddr == `OASF_OFF_CTRL) begin
            ctrlHold_ff <= pwdata[`OASF_CTRL_HOLD_POS];
        end
    end

    // one wait state: pready rises the cycle after the access phase starts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            apbState_ff <= OASF_APB_IDLE;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            case (apbState_ff)
                OASF_APB_IDLE: begin
                    if (psel && penable) begin
                        apbState_ff <= OASF_APB_RESP;
                        pready_ff <= 1'b1;
                        pslverr_ff <= !isMapped(paddr);
                        if (pwrite) begin
                            prdata_ff <= 32'h00000000;
                        end else if (paddr == `OASF_OFF_FLAGS) begin
                            prdata_ff <= {16'h0000, flags_ff};
                        end else if (paddr == `OASF_OFF_CTRL) begin
                            prdata_ff <= {31'h00000000, ctrlHold_ff};
                        end else if (paddr == `OASF_OFF_LAST_EA) begin
                            prdata_ff <= {16'h0000, lastEa_ff};
                        end else begin
                            prdata_ff <= 32'h00000000;
                        end
                    end
                end
                default: begin
                    apbState_ff <= OASF_APB_IDLE;
                    pready_ff <= 1'b0;
                    pslverr_ff <= 1'b0;
                end
            endcase
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign eaRspValid = eaRspValid_ff;
    assign eaRsp = eaRsp_ff;
    assign flagsUpdated = flagsUpdated_ff;
    assign cpuFlags = flags_ff;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_reg_mode_kind: assert property (
        eaReqValid && !eaReq.immed && !eaReq.dstSide
        && eaReq.instr[`OASF_TS_LSB +: 2] == 2'b00
        |=> eaRspValid && eaRsp.kind == OASF_EA_REG)
        else $error("register mode did not give register operand");

    a_autoinc_step: assert property (
        eaReqValid && !eaReq.immed && !eaReq.dstSide
        && eaReq.instr[`OASF_TS_LSB +: 2] == 2'b11
        |=> eaRsp.ptrWr && eaRsp.addr == $past(eaReq.regVal)
        && eaRsp.ptrNext == $past(eaReq.regVal)
        + (eaRsp.byteOp ? 16'h0001 : 16'h0002))
        else $error("auto-increment address or step wrong");

    a_direct_index: assert property (
        eaReqValid && !eaReq.immed && !eaReq.dstSide
        && eaReq.instr[`OASF_TS_LSB +: 2] == 2'b10
        |=> eaRsp.extUsed && eaRsp.addr == $past(eaReq.extWord)
        + ((eaRsp.regSel == 4'h0) ? 16'h0000 : $past(eaReq.regVal)))
        else $error("direct or indexed address wrong");

    a_imm_operand: assert property (
        eaReqValid && eaReq.immed
        |=> eaRsp.kind == OASF_EA_IMM && eaRsp.addr == $past(eaReq.extWord))
        else $error("immediate operand not taken from extension word");

    a_pc_relative: assert property (
        eaReqValid |=> eaRsp.pcTarget - $past(eaReq.pc)
        == {{7{$past(eaReq.instr[7])}}, $past(eaReq.instr[7:0]), 1'b0})
        else $error("jump target not pc plus doubled displacement");

    a_bit_address: assert property (
        eaReqValid |=> eaRsp.bitAddr == $past(eaReq.serialBase[12:1])
        + {{4{$past(eaReq.instr[7])}}, $past(eaReq.instr[7:0])})
        else $error("serial bit address wrong");

    a_reserved_zero: assert property (
        cpuFlags[`OASF_RSVD_HI:`OASF_RSVD_LO] == 5'h00)
        else $error("reserved status bits not zero");

    a_cmp_equal: assert property (
        flagReqValid && !ctrlHold_ff && flagReq.op == OASF_OP_CMP
        && !flagReq.byteOp
        |=> cpuFlags[`OASF_EQ_POS] == ($past(flagReq.src)
        == $past(flagReq.dst)))
        else $error("compare equal flag wrong");

    a_tb_keeps: assert property (
        flagReqValid && !ctrlHold_ff && flagReq.op == OASF_OP_TB
        |=> cpuFlags[`OASF_EQ_POS] == $past(flagReq.serialInBit)
        && {cpuFlags[15:14], cpuFlags[12:0]}
        == $past({cpuFlags[15:14], cpuFlags[12:0]}))
        else $error("bit test disturbed other flags");

    a_xop_set: assert property (
        flagReqValid && !ctrlHold_ff && flagReq.op == OASF_OP_XOP
        |=> flagsUpdated && cpuFlags[`OASF_XOP_POS])
        else $error("extended-operation flag not set");

    a_mask_load: assert property (
        flagReqValid && !ctrlHold_ff && flagReq.op == OASF_OP_MASK_LOAD_OP
        |=> cpuFlags[3:0] == $past(flagReq.src[3:0])
        && cpuFlags[15:9] == $past(cpuFlags[15:9]))
        else $error("interrupt mask load wrong");

    a_add_ovf: assert property (
        flagReqValid && !ctrlHold_ff && flagReq.op == OASF_OP_ADD
        && !flagReq.byteOp && flagReq.src[15] == flagReq.dst[15]
        && flagReq.result[15] != flagReq.dst[15]
        |=> cpuFlags[`OASF_OVF_POS])
        else $error("add overflow missed");
endmodule // oasf_core

// File: oasf_seq_model.sv
// sequencer stand-in that launches effective address requests
`timescale 1ns/1ps
module oasf_seq_model import oasf_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic issue,
    input wire oasf_ea_req_t nextReq,
    output logic eaReqValid,
    output oasf_ea_req_t eaReq
);
    // between requests the request lines toggle so stale values never match
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eaReqValid <= 1'b0;
            eaReq <= '0;
        end else begin
            eaReqValid <= issue;
            eaReq <= issue ? nextReq : ~eaReq;
        end
    end
endmodule // oasf_seq_model

// File: operand_address_and_status_flags_tb.sv
// self-checking bench for the address and status flag block
`timescale 1ns/1ps
module operand_address_and_status_flags_tb import oasf_pkg::*;;
    logic clk = 1'b0, rst_n = 1'b0, issue = 1'b0, flagReqValid = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ds = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, eaReqValid, eaRspValid, flagsUpdated;
    logic [15:0] cpuFlags, r, e, v;
    logic [18:0] s;
    oasf_ea_req_t nextReq = '0, eaReq;
    oasf_ea_rsp_t eaRsp;
    oasf_flag_req_t flagReq = '0;
    int miscompares = 0, checked = 0;
    logic [32:0] qR[$], qF[$];
    logic [18:0] qE[$];

    oasf_core dut_u (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .eaReqValid(eaReqValid), .eaReq(eaReq), .eaRspValid(eaRspValid),
        .eaRsp(eaRsp), .flagReqValid(flagReqValid), .flagReq(flagReq),
        .flagsUpdated(flagsUpdated), .cpuFlags(cpuFlags));
    oasf_seq_model seq_u (.clk(clk), .rst_n(rst_n), .issue(issue),
        .nextReq(nextReq), .eaReqValid(eaReqValid), .eaReq(eaReq));

    initial begin
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("compares %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, input logic [32:0] x);
        int n = 0;
        if (!w) qR.push_back(x);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        // a slave that never answers ends the run as a failure
        if (pready !== 1'b1) begin
            miscompares++;
            finish_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic flg(input oasf_flag_req_t q, input logic [15:0] ex,
            input logic note);
        if (note) qF.push_back({17'h0, ex});
        flagReqValid <= 1'b1;
        flagReq <= q;
        @(posedge clk);
        flagReqValid <= 1'b0;
        flagReq <= ~q;
        @(posedge clk);
    endtask

    task automatic ea(input logic [15:0] ins, input logic imm,
            input logic [2:0] sel, input logic [15:0] ev);
        qE.push_back({sel, ev});
        nextReq <= '{instr:ins, dstSide:ds, immed:imm, regVal:r,
            extWord:e, pc:r, serialBase:r};
        issue <= 1'b1;
        @(posedge clk);
        issue <= 1'b0;
        @(posedge clk);
    endtask

    // results are matched against the oldest note of their kind
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk({pslverr, prdata}, qR.pop_front());
        if (flagsUpdated === 1'b1) begin
            if (qF.size() == 0) chk(33'h1, 33'h0);
            else chk({17'h0, cpuFlags}, qF.pop_front());
        end
        if (eaRspValid === 1'b1 && qE.size() > 0) begin
            s = qE.pop_front();
            case (s[18:16])
                3'd0: v = eaRsp.addr;
                3'd1: v = eaRsp.ptrNext;
                3'd2: v = eaRsp.pcTarget;
                3'd3: v = {4'h0, eaRsp.bitAddr};
                default: v = {14'h0, eaRsp.kind};
            endcase
            chk({17'h0, v}, {17'h0, s[15:0]});
        end
    end

    initial begin
        void'($urandom(32'hb2c3));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, 12'h000, 32'h0, 33'h0);
        apb(1'b1, 12'h000, 32'hffff, 33'h0);
        apb(1'b0, 12'h000, 32'h0, 33'h0fe0f);
        apb(1'b0, 12'h00c, 32'h0, 33'h100000000);
        apb(1'b1, 12'h000, 32'h0, 33'h0);
        $display("register test done");
        flg('{op:OASF_OP_XOP, default:'0}, 16'h0200, 1'b1);
        flg('{op:OASF_OP_MASK_LOAD_OP, src:16'h000a, default:'0}, 16'h020a,
            1'b1);
        flg('{op:OASF_OP_ADD, src:16'h7fff, dst:16'h0001, result:16'h8000,
            carryOut:1'b1, default:'0}, 16'h9a0a,
            1'b1);
        flg('{op:OASF_OP_SUB, src:16'h0001, dst:16'h8000, result:16'h7fff,
            carryOut:1'b1, default:'0}, 16'hda0a, 1'b1);
        flg('{op:OASF_OP_CMP, src:16'h0001, dst:16'h8000, default:'0},
            16'h5a0a, 1'b1);
        flg('{op:OASF_OP_TB, serialInBit:1'b1, default:'0}, 16'h7a0a,
            1'b1);
        flg('{op:OASF_OP_CMPI, src:16'h0002, dst:16'h0001, default:'0},
            16'hda0a, 1'b1);
        flg('{op:OASF_OP_DEC, src:16'h8000, result:16'h7fff, default:'0},
            16'hca0a, 1'b1);
        flg('{op:OASF_OP_ABS, src:16'h8000, result:16'h8000, default:'0},
            16'h8a0a, 1'b1);
        flg('{op:OASF_OP_DIV, src:16'h0004, dst:16'h0003, default:'0},
            16'h820a, 1'b1);
        flg('{op:OASF_OP_MOVE, byteOp:1'b1, src:16'h0700, result:16'h0700,
            default:'0}, 16'hc60a, 1'b1);
        $display("flag test done");
        apb(1'b1, 12'h004, 32'h1, 33'h0);
        apb(1'b0, 12'h004, 32'h0, 33'h1);
        flg('{op:OASF_OP_MASK_LOAD_OP, src:16'h0005, default:'0}, 16'h0, 1'b0);
        apb(1'b1, 12'h004, 32'h0, 33'h0);
        apb(1'b0, 12'h000, 32'h0, 33'h0c60a);
        flg('{op:OASF_OP_CONTEXT_RETURN, src:16'hffff, default:'0}, 16'hfe0f,
            1'b1);
        apb(1'b0, 12'h000, 32'h0, 33'h0fe0f);
        $display("hold test done");
        flg('{op:OASF_OP_SERIAL, src:16'h0001, result:16'h0001,
            bitCount:5'd9, default:'0}, 16'hda0f, 1'b1);
        flg('{op:OASF_OP_SERIAL, src:16'h0001, result:16'h0001,
            bitCount:5'd1, default:'0}, 16'hde0f, 1'b1);
        flg('{op:OASF_OP_SLA, src:16'h4000, result:16'h8000,
            shiftOut:1'b1, bitCount:5'd1, default:'0},
            16'h9e0f, 1'b1);
        flg('{op:OASF_OP_COC, src:16'h00f0, dst:16'h00ff, default:'0},
            16'hbe0f, 1'b1);
        flg('{op:OASF_OP_CZC, src:16'h00f0, dst:16'h00ff, default:'0},
            16'h9e0f, 1'b1);
        $display("shift test done");
        repeat (2) begin
            r = 16'($urandom);
            e = 16'($urandom);
            ea(16'h0003, 1'b0, 3'd4, 16'(OASF_EA_REG));
            ea(16'h0013, 1'b0, 3'd0, r);
            ea(16'h0032, 1'b0, 3'd0, r);
            ea(16'h0032, 1'b0, 3'd1, r + 16'h0002);
            ea(16'h1032, 1'b0, 3'd1, r + 16'h0001);
            ea(16'h0020, 1'b0, 3'd0, e);
            ea(16'h0025, 1'b0, 3'd0, e + r);
            ds = 1'b1;
            ea(16'h0c40, 1'b0, 3'd1, r + 16'h0002);
            ds = 1'b0;
            ea(16'h0000, 1'b1, 3'd4, 16'(OASF_EA_IMM));
            ea(16'h0080, 1'b0, 3'd2, r - 16'h0100);
            ea(16'h00fe, 1'b0, 3'd3, {4'h0, r[12:1] - 12'h002});
        end
        $display("address test done");
        apb(1'b0, 12'h008, 32'h0, {17'h0, r});
        for (int i = 0; i < 20 && qE.size() + qF.size() + qR.size() > 0; i++)
            @(posedge clk);
        if (qE.size() + qF.size() + qR.size() > 0) miscompares++;
        finish_test();
    end
endmodule // operand_address_and_status_flags_tb
